/* File: dv/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Core side model: takes the offered vector once per request episode
module core_model #(
  parameter int DELAY = 2
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_irq,
  input  wire logic i_ack_en,
  output logic      o_ack
);
  int cnt_q;

  // Count cycles of a standing request; restart when it drops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 0;
    end else if (!i_irq) begin
      cnt_q <= 0;
    end else if (cnt_q <= DELAY) begin
      cnt_q <= cnt_q + 1;
    end
  end

  // Ack only while the request stands, so no status is set for a vanished one
  assign o_ack = i_irq && i_ack_en && (cnt_q == DELAY);
endmodule
`default_nettype wire

/* File: dv/irq_arbiter_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter_unit_tb_top;
  import irq_arbiter_pkg::*;
  typedef struct {int s; logic [1:0] c; logic [1:0] m; logic q;} row_t;
  logic               clk;
  logic               rst_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [APB_AW-1:0]  paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic               pslverr;
  logic [31:0]        prdata;
  logic [NUM_SRC-1:0] irq_src;
  logic [1:0]         core_mask;
  logic               core_ack;
  logic               core_irq;
  logic [1:0]         core_level;
  logic [VEC_W-1:0]   core_vector;
  logic               core_fast;
  logic [VADDR_W-1:0] vec_addr;
  logic               boot_drive;
  logic               low_power;
  logic               wake_req;
  logic               irq;
  logic               ack_en;
  logic [31:0]        rd;
  logic               err;
  int                 n_errors;
  int                 compares;
  logic [31:0]        prio [3] = '{default: 32'h0000_0000};
  localparam logic [VBASE_W-1:0] VB = 14'h2a5f;
  // Source, level code, core mask, expected request
  row_t rows [8] = '{'{5, 2'h1, 2'h0, 1'b1}, '{5, 2'h1, 2'h1, 1'b0}, '{5, 2'h2, 2'h1, 1'b1},
    '{5, 2'h2, 2'h2, 1'b0}, '{5, 2'h3, 2'h2, 1'b1}, '{5, 2'h3, 2'h3, 1'b0},
    '{5, 2'h0, 2'h0, 1'b0}, '{45, 2'h3, 2'h0, 1'b1}};

  irq_arbiter_unit i_irq_arbiter_unit (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_irq_src(irq_src), .i_core_mask(core_mask), .i_core_ack(core_ack),
    .o_core_irq(core_irq), .o_core_level(core_level), .o_core_vector(core_vector),
    .o_core_fast(core_fast), .o_core_vec_addr(vec_addr), .o_boot_drive(boot_drive),
    .i_low_power(low_power), .o_wake_req(wake_req), .o_irq(irq));

  core_model i_core_model (.i_clock(clk), .i_rst_n(rst_n), .i_irq(core_irq),
    .i_ack_en(ack_en), .o_ack(core_ack));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //============================================================================
  // Helpers
  function automatic logic [7:0] ba(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  function automatic logic [VADDR_W-1:0] va(input int s);
    return {VB, 7'(s)};
  endfunction

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Shadow keeps the other fields of the shared level register intact
  task automatic set_lvl(input int n, input logic [1:0] c);
    logic [31:0] r;
    logic        e;
    prio[n / 16][2 * (n % 16) +: 2] = c;
    apb(1'b1, ba(5'(n / 16)), prio[n / 16], r, e);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic obs(input logic q, input logic [1:0] l, input int v, input logic f,
                     input logic [VADDR_W-1:0] a);
    settle();
    chk("core_irq", 32'(q), 32'(core_irq));
    if (q) begin
      chk("level", 32'(l), 32'(core_level));
      chk("vector", 32'(v), 32'(core_vector));
      chk("fast", 32'(f), 32'(core_fast));
      chk("vec_addr", 32'(a), 32'(vec_addr));
    end
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 20 && irq !== 1'b1; k++) begin
      @(posedge clk);
    end
    if (irq !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask

  // Hang guard well beyond the run length of the main sequence
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end

  //============================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    irq_src = {NUM_SRC{1'b0}};
    core_mask = 2'h0;
    low_power = 1'b0;
    ack_en = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("boot_drive", 32'h1, 32'(boot_drive));
    chk("boot_addr", 32'(BOOT_ADDR), 32'(vec_addr));
    chk("core_irq", 32'h0, 32'(core_irq));
    $display("test reset done");
    apb(1'b1, ba(IDX_VBASE), 32'(VB), rd, err);
    apb(1'b0, ba(IDX_VBASE), 32'h0, rd, err);
    chk("vbase", 32'(VB), rd);
    apb(1'b0, ba(IDX_FM0), 32'h0, rd, err);
    chk("fm0_reset", 32'(FM_RST), rd);
    apb(1'b1, ba(IDX_FVH0), 32'hffff_ffff, rd, err);
    apb(1'b0, ba(IDX_FVH0), 32'h0, rd, err);
    chk("fvh0_width", 32'h0000_001f, rd);
    apb(1'b0, 8'h80, 32'h0, rd, err);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, rd);
    $display("test registers done");
    // Level codes 1..3 against the core mask equal to their level and the next mask up, then code 0 and source 45
    foreach (rows[r]) begin
      set_lvl(rows[r].s, rows[r].c);
      @(posedge clk);
      core_mask <= rows[r].m;
      irq_src[rows[r].s] <= 1'b1;
      obs(rows[r].q, rows[r].c - 2'h1, rows[r].s, 1'b0, va(rows[r].s));
      @(posedge clk);
      irq_src <= {NUM_SRC{1'b0}};
      set_lvl(rows[r].s, 2'h0);
    end
    chk("boot_released", 32'h0, 32'(boot_drive));
    $display("test mask table done");
    set_lvl(7, 2'h2);
    set_lvl(3, 2'h2);
    set_lvl(9, 2'h3);
    @(posedge clk);
    irq_src <= 46'h0000_0000_0088;
    obs(1'b1, 2'h1, 3, 1'b0, va(3));
    apb(1'b0, ba(IDX_PEND0), 32'h0, rd, err);
    chk("pending", 32'h0000_0088, rd);
    @(posedge clk);
    irq_src[9] <= 1'b1;
    obs(1'b1, 2'h2, 9, 1'b0, va(9));
    @(posedge clk);
    irq_src[9] <= 1'b0;
    core_mask <= 2'h2;
    obs(1'b0, 2'h0, 0, 1'b0, 21'h00_0000);
    @(posedge clk);
    irq_src <= 46'h0000_0000_0001;
    core_mask <= 2'h3;
    obs(1'b1, LVL_FIXED, 0, 1'b0, va(0));
    apb(1'b1, ba(IDX_CTRL), 32'h0000_0001, rd, err);
    obs(1'b0, 2'h0, 0, 1'b0, 21'h00_0000);
    apb(1'b1, ba(IDX_CTRL), 32'h0000_0000, rd, err);
    @(posedge clk);
    irq_src <= {NUM_SRC{1'b0}};
    core_mask <= 2'h0;
    $display("test arbitration done");
    // Fast slot 1, then the same source one level lower
    apb(1'b1, ba(IDX_IMSK), 32'h0000_0003, rd, err);
    set_lvl(12, 2'h3);
    apb(1'b1, ba(IDX_FM1), 32'h0000_000c, rd, err);
    apb(1'b1, ba(IDX_FVL1), 32'h0000_1234, rd, err);
    apb(1'b1, ba(IDX_FVH1), 32'h0000_0015, rd, err);
    @(posedge clk);
    ack_en <= 1'b1;
    irq_src[12] <= 1'b1;
    obs(1'b1, 2'h2, 12, 1'b1, 21'h15_1234);
    wait_irq();
    apb(1'b0, ba(IDX_STAT), 32'h0, rd, err);
    chk("status_fast", 32'h0000_0002, rd);
    settle();
    chk("irq_cleared", 32'h0, 32'(irq));
    @(posedge clk);
    irq_src[12] <= 1'b0;
    set_lvl(12, 2'h2);
    @(posedge clk);
    irq_src[12] <= 1'b1;
    obs(1'b1, 2'h1, 12, 1'b0, va(12));
    wait_irq();
    apb(1'b0, ba(IDX_STAT), 32'h0, rd, err);
    chk("status_norm", 32'h0000_0001, rd);
    // Slot 0 matches the same source too and takes precedence over slot 1
    apb(1'b1, ba(IDX_FM0), 32'h0000_000c, rd, err);
    apb(1'b1, ba(IDX_FVL0), 32'h0000_5678, rd, err);
    set_lvl(12, 2'h3);
    obs(1'b1, 2'h2, 12, 1'b1, 21'h1f_5678);
    $display("test fast done");
    // Wake only from a source enabled before entry
    @(posedge clk);
    ack_en <= 1'b0;
    irq_src <= {NUM_SRC{1'b0}};
    set_lvl(20, 2'h1);
    @(posedge clk);
    low_power <= 1'b1;
    set_lvl(21, 2'h1);
    @(posedge clk);
    irq_src[21] <= 1'b1;
    settle();
    chk("wake_late", 32'h0, 32'(wake_req));
    @(posedge clk);
    irq_src[20] <= 1'b1;
    settle();
    chk("wake", 32'h1, 32'(wake_req));
    chk("irq_masked", 32'h0, 32'(irq));
    @(posedge clk);
    low_power <= 1'b0;
    irq_src <= {NUM_SRC{1'b0}};
    apb(1'b0, ba(IDX_STAT), 32'h0, rd, err);
    chk("status_wake", 32'h0000_0004, rd);
    $display("test wake done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: rtl/arb_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries the qualified requests to the level selector and the winner back
interface arb_if;
  import irq_arbiter_pkg::*;
  logic [NUM_SRC-1:0]       act;
  logic [NUM_SRC-1:0][1:0]  lvl;
  logic [1:0]               mask;
  logic                     win_valid;
  logic [SRC_W-1:0]         win_src;
  logic [1:0]               win_lvl;

  modport sel (input act, input lvl, input mask,
               output win_valid, output win_src, output win_lvl);
  modport ctl (output act, output lvl, output mask,
               input win_valid, input win_src, input win_lvl);
endinterface
`default_nettype wire

/* File: rtl/irq_arbiter_pkg.sv */
//==============================================================================
// Overview of operation
// [R01] Each of 46 sources takes one of four levels; fixed sources ignore programming.
// [R02] Within one level the lowest-numbered active source wins; 0 highest, 45 lowest.
// [R03] Arbitrate pending requests, flag a sufficient one, supply its vector address.
// [R04] In wait or stop, a pending request asks the clock unit to restart clocks.
// [R05] Only sources enabled before entering wait or stop may wake the chip.
// [R06] Normal vector address is vector base concatenated with the winning vector number.
// [R07] Core mask 00 allows all, 01 masks 0, 10 masks 0-1, 11 allows 3.
// [R08] Nesting: a higher level than the one in service may still be taken.
// [R09] Winning vector is compared with both match slots; level-2 match means fast.
// [R10] A fast request supplies the slot's low and high address instead.
// [R11] Fast requests are recognised here, before the core sees them.
// [R12] Software sets level 2, the match number and the slot address for fast.
// [R13] Core fetches at the vector address and starts fast handling unless a subroutine jump.
// [R14] After reset the block drives the initial fetch address.
// [R15] Vector base at index 5; match slots at 6 and 9, each with low then high.
// [R16] With no permitted enabled pending request, the core request stays low.
//==============================================================================
package irq_arbiter_pkg;

  // ===========================================================================
  // Sizes
  localparam int NUM_SRC      = 46;
  localparam int NUM_FIXED    = 2;
  localparam int PRIO_PER_REG = 16;
  localparam int PRIO_SLOTS   = 48;
  localparam int SRC_W        = 6;
  localparam int VBASE_W      = 14;
  localparam int VEC_W        = 7;
  localparam int FVL_W        = 16;
  localparam int FVH_W        = 5;
  localparam int VADDR_W      = 21;
  localparam int APB_AW       = 8;
  localparam int NUM_EV       = 3;

  // ===========================================================================
  // Register indices, byte address is four times the index
  localparam logic [4:0] IDX_PRIO0 = 5'h00;
  localparam logic [4:0] IDX_PRIO1 = 5'h01;
  localparam logic [4:0] IDX_PRIO2 = 5'h02;
  localparam logic [4:0] IDX_VBASE = 5'h05;
  localparam logic [4:0] IDX_FM0   = 5'h06;
  localparam logic [4:0] IDX_FVL0  = 5'h07;
  localparam logic [4:0] IDX_FVH0  = 5'h08;
  localparam logic [4:0] IDX_FM1   = 5'h09;
  localparam logic [4:0] IDX_FVL1  = 5'h0a;
  localparam logic [4:0] IDX_FVH1  = 5'h0b;
  localparam logic [4:0] IDX_PEND0 = 5'h0c;
  localparam logic [4:0] IDX_PEND1 = 5'h0d;
  localparam logic [4:0] IDX_CTRL  = 5'h12;
  localparam logic [4:0] IDX_STAT  = 5'h13;
  localparam logic [4:0] IDX_IMSK  = 5'h14;

  // ===========================================================================
  // Field positions
  localparam int CTRL_DIS_BIT  = 0;
  localparam int CTRL_MASK_LSB = 1;
  localparam int CTRL_IRQ_BIT  = 3;
  localparam int EV_ACK_NORM   = 0;
  localparam int EV_ACK_FAST   = 1;
  localparam int EV_WAKE       = 2;

  // ===========================================================================
  // Levels and reset values
  localparam logic [1:0]         LVL_FAST   = 2'h2;
  localparam logic [1:0]         LVL_FIXED  = 2'h3;
  localparam logic [1:0]         PRIO_OFF   = 2'h0;
  localparam logic [VBASE_W-1:0] VBASE_RST  = 14'h0000;
  localparam logic [VEC_W-1:0]   FM_RST     = 7'h00;
  localparam logic [FVL_W-1:0]   FVL_RST    = 16'h0000;
  localparam logic [FVH_W-1:0]   FVH_RST    = 5'h00;
  localparam logic [VADDR_W-1:0] BOOT_ADDR  = 21'h00_0000;
  localparam logic [31:0]        RDATA_ZERO = 32'h0000_0000;

endpackage

/* File: rtl/irq_arbiter_unit.sv */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter_unit
  import irq_arbiter_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  // APB slave
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [APB_AW-1:0]   i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  output logic [31:0]              o_prdata,
  // Interrupt sources and core side
  input  wire logic [NUM_SRC-1:0]  i_irq_src,
  input  wire logic [1:0]          i_core_mask,
  input  wire logic                i_core_ack,
  output logic                     o_core_irq,
  output logic [1:0]               o_core_level,
  output logic [VEC_W-1:0]         o_core_vector,
  output logic                     o_core_fast,
  output logic [VADDR_W-1:0]       o_core_vec_addr,
  output logic                     o_boot_drive,
  // Clock restart handshake with the system integration unit
  input  wire logic                i_low_power,
  output logic                     o_wake_req,
  // Interrupt to software
  output logic                     o_irq
);

  // ===========================================================================
  // Declarations
  wire logic [PRIO_SLOTS-1:0][1:0] prio_q;
  logic [NUM_SRC-1:0]         en;
  logic [NUM_SRC-1:0][1:0]    lvl;
  logic [VBASE_W-1:0]         vbase_q;
  logic [VEC_W-1:0]           fm0_q;
  logic [VEC_W-1:0]           fm1_q;
  logic [FVL_W-1:0]           fvl0_q;
  logic [FVL_W-1:0]           fvl1_q;
  logic [FVH_W-1:0]           fvh0_q;
  logic [FVH_W-1:0]           fvh1_q;
  logic                       dis_q;
  logic [NUM_EV-1:0]          st_q;
  logic [NUM_EV-1:0]          st_d;
  logic [NUM_EV-1:0]          msk_q;
  logic [NUM_EV-1:0]          ev;
  logic [NUM_SRC-1:0]         wake_en_q;
  logic                       wake_d;
  logic                       pready_q;
  logic                       pslverr_q;
  logic [31:0]                prdata_q;
  logic [31:0]                rdata;
  logic                       mapped;
  logic [4:0]                 idx;
  logic                       setup;
  logic                       wr;
  logic                       rd_stat;
  logic                       hit0;
  logic                       hit1;
  logic [VEC_W-1:0]           win_vec;
  logic                       core_irq_q;
  logic [1:0]                 core_level_q;
  logic [VEC_W-1:0]           core_vector_q;
  logic                       core_fast_q;
  logic [VADDR_W-1:0]         vec_addr_q;
  logic                       boot_q;
  logic                       wake_q;
  logic                       irq_q;

  arb_if arb ();

  // ===========================================================================
  // Level fields per source
  // Fixed sources hold no flops at all, so writes to them cannot stick.
  // Field code 0 disables, codes 1..3 give levels 0..2.
  for (genvar n = 0; n < PRIO_SLOTS; n++) begin : g_src
    if (n < NUM_FIXED || n >= NUM_SRC) begin : g_fixed
      assign prio_q[n] = PRIO_OFF;                            // [R01]
    end else begin : g_prog
      logic [1:0] fld_q;
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          fld_q <= PRIO_OFF;
        end else if (wr && idx == 5'(n / PRIO_PER_REG)) begin
          fld_q <= i_pwdata[2*(n%PRIO_PER_REG) +: 2];         // [R01]
        end
      end
      assign prio_q[n] = fld_q;
    end
    if (n < NUM_SRC) begin : g_eff
      assign en[n]  = (n < NUM_FIXED) ? 1'b1 : (prio_q[n] != PRIO_OFF);
      assign lvl[n] = (n < NUM_FIXED) ? LVL_FIXED : 2'(prio_q[n] - 2'h1);
    end
  end

  // ===========================================================================
  // Arbitration
  assign arb.act  = i_irq_src & en;                           // [R03]
  assign arb.lvl  = lvl;
  assign arb.mask = i_core_mask;                              // [R08]

  irq_level_select u_select (
    .bus (arb)
  );

  // Fast match is decided here so the core gets the slot address directly
  assign win_vec = VEC_W'(arb.win_src);
  assign hit0    = (arb.win_lvl == LVL_FAST) && (win_vec == fm0_q);  // [R09]
  assign hit1    = (arb.win_lvl == LVL_FAST) && (win_vec == fm1_q);  // [R09]

  // ===========================================================================
  // Core request and vector
  // Address holds its last value between requests; until the first one it
  // stays on the boot address.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_irq_q    <= 1'b0;
      core_level_q  <= 2'h0;
      core_vector_q <= FM_RST;
      core_fast_q   <= 1'b0;
      vec_addr_q    <= BOOT_ADDR;                             // [R14]
    end else begin
      core_irq_q <= arb.win_valid && !dis_q;                  // [R16]
      if (arb.win_valid) begin
        core_level_q  <= arb.win_lvl;
        core_vector_q <= win_vec;
        core_fast_q   <= hit0 || hit1;                        // [R11]
        if (hit0) begin
          vec_addr_q <= {fvh0_q, fvl0_q};                     // [R10]
        end else if (hit1) begin
          vec_addr_q <= {fvh1_q, fvl1_q};                     // [R10]
        end else begin
          vec_addr_q <= {vbase_q, win_vec};                   // [R06]
        end
      end
    end
  end

  // Boot drive ends once the first real vector replaces the initial address
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_q <= 1'b1;
    end else if (arb.win_valid) begin
      boot_q <= 1'b0;                                         // [R14]
    end
  end

  // ===========================================================================
  // Wake from wait and stop
  // Enables are frozen at entry, so enabling a source later cannot wake.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_en_q <= '0;
    end else if (!i_low_power) begin
      wake_en_q <= en;                                        // [R05]
    end
  end

  assign wake_d = i_low_power && |(i_irq_src & wake_en_q);    // [R04]

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // ===========================================================================
  // APB decode
  // Answer comes in the first access cycle: no wait states.
  assign idx     = i_paddr[6:2];
  assign setup   = i_psel && !i_penable;
  assign wr      = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
  assign rd_stat = i_psel && i_penable && pready_q && !i_pwrite && idx == IDX_STAT;

  always_comb begin
    rdata  = RDATA_ZERO;
    mapped = !i_paddr[7];
    unique case (idx)
      IDX_PRIO0: rdata = prio_q[PRIO_PER_REG*0 +: PRIO_PER_REG];
      IDX_PRIO1: rdata = prio_q[PRIO_PER_REG*1 +: PRIO_PER_REG];
      IDX_PRIO2: rdata = prio_q[PRIO_PER_REG*2 +: PRIO_PER_REG];
      IDX_VBASE: rdata[VBASE_W-1:0] = vbase_q;                // [R15]
      IDX_FM0:   rdata[VEC_W-1:0]   = fm0_q;
      IDX_FVL0:  rdata[FVL_W-1:0]   = fvl0_q;
      IDX_FVH0:  rdata[FVH_W-1:0]   = fvh0_q;
      IDX_FM1:   rdata[VEC_W-1:0]   = fm1_q;
      IDX_FVL1:  rdata[FVL_W-1:0]   = fvl1_q;
      IDX_FVH1:  rdata[FVH_W-1:0]   = fvh1_q;
      IDX_PEND0: rdata = arb.act[31:0];
      IDX_PEND1: rdata[NUM_SRC-33:0] = arb.act[NUM_SRC-1:32];
      IDX_CTRL: begin
        rdata[CTRL_DIS_BIT]              = dis_q;
        rdata[CTRL_MASK_LSB +: 2]        = i_core_mask;
        rdata[CTRL_IRQ_BIT]              = core_irq_q;
      end
      IDX_STAT:  rdata[NUM_EV-1:0] = st_q;
      IDX_IMSK:  rdata[NUM_EV-1:0] = msk_q;
      default:   mapped = 1'b0;
    endcase
  end

  // Read data is captured at setup; the status clear later uses this copy
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_ZERO;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) begin
        prdata_q <= (i_pwrite || !mapped) ? RDATA_ZERO : rdata;
      end
    end
  end

  // ===========================================================================
  // Writable registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vbase_q <= VBASE_RST;
      fm0_q   <= FM_RST;
      fm1_q   <= FM_RST;
      fvl0_q  <= FVL_RST;
      fvl1_q  <= FVL_RST;
      fvh0_q  <= FVH_RST;
      fvh1_q  <= FVH_RST;
      dis_q   <= 1'b0;
      msk_q   <= '0;
    end else if (wr) begin
      unique case (idx)
        IDX_VBASE: vbase_q <= i_pwdata[VBASE_W-1:0];          // [R15]
        IDX_FM0:   fm0_q   <= i_pwdata[VEC_W-1:0];
        IDX_FVL0:  fvl0_q  <= i_pwdata[FVL_W-1:0];
        IDX_FVH0:  fvh0_q  <= i_pwdata[FVH_W-1:0];
        IDX_FM1:   fm1_q   <= i_pwdata[VEC_W-1:0];
        IDX_FVL1:  fvl1_q  <= i_pwdata[FVL_W-1:0];
        IDX_FVH1:  fvh1_q  <= i_pwdata[FVH_W-1:0];
        IDX_CTRL:  dis_q   <= i_pwdata[CTRL_DIS_BIT];
        IDX_IMSK:  msk_q   <= i_pwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // ===========================================================================
  // Event status, cleared by reading it
  // Only bits that were actually returned are cleared, and a new event in the
  // clearing cycle wins, so nothing is lost between setup and access.
  assign ev[EV_ACK_NORM] = i_core_ack && core_irq_q && !core_fast_q;
  assign ev[EV_ACK_FAST] = i_core_ack && core_irq_q && core_fast_q;
  assign ev[EV_WAKE]     = wake_d && !wake_q;
  assign st_d = (st_q & ~(rd_stat ? prdata_q[NUM_EV-1:0] : '0)) | ev;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q  <= '0;
      irq_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      irq_q <= |(st_d & msk_q);
    end
  end

  // ===========================================================================
  // Outputs
  assign o_pready        = pready_q;
  assign o_pslverr       = pslverr_q;
  assign o_prdata        = prdata_q;
  assign o_core_irq      = core_irq_q;
  assign o_core_level    = core_level_q;
  assign o_core_vector   = core_vector_q;
  assign o_core_fast     = core_fast_q;
  assign o_core_vec_addr = vec_addr_q;
  assign o_boot_drive    = boot_q;
  assign o_wake_req      = wake_q;
  assign o_irq           = irq_q;

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_no_req;
    !arb.win_valid |=> !o_core_irq;
  endproperty
  a_no_req: assert property (p_no_req) else $error("core request without winner"); // [R16]

  property p_req;
    (arb.win_valid && !dis_q) |=> o_core_irq;
  endproperty
  a_req: assert property (p_req) else $error("winner not signalled to core"); // [R03]

  property p_mask;
    o_core_irq |-> (o_core_level >= $past(i_core_mask));
  endproperty
  a_mask: assert property (p_mask) else $error("masked level reached core"); // [R07]

  property p_fixed;
    (arb.win_valid && arb.win_src < SRC_W'(NUM_FIXED)) |-> arb.win_lvl == LVL_FIXED;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed source level wrong"); // [R01]

  property p_norm_addr;
    (o_core_irq && !o_core_fast) |-> o_core_vec_addr == {$past(vbase_q), o_core_vector};
  endproperty
  a_norm_addr: assert property (p_norm_addr) else $error("normal vector address wrong"); // [R06]

  property p_fast_lvl;
    o_core_fast && o_core_irq |-> o_core_level == LVL_FAST;
  endproperty
  a_fast_lvl: assert property (p_fast_lvl) else $error("fast taken off level two"); // [R09]

  property p_fast_addr;
    (o_core_irq && o_core_fast && o_core_vector == $past(fm0_q))
      |-> o_core_vec_addr == {$past(fvh0_q), $past(fvl0_q)};
  endproperty
  a_fast_addr: assert property (p_fast_addr) else $error("fast slot address wrong"); // [R10]

  property p_wake;
    (i_low_power && |(i_irq_src & wake_en_q)) |=> o_wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not requested"); // [R04]

  property p_wake_only_lp;
    o_wake_req |-> $past(i_low_power) && $past(wake_d);
  endproperty
  a_wake_only_lp: assert property (p_wake_only_lp) else $error("spurious wake"); // [R05]

  property p_boot;
    o_boot_drive |-> o_core_vec_addr == BOOT_ADDR ##1 (o_boot_drive || o_core_irq || $past(dis_q));
  endproperty
  a_boot: assert property (p_boot) else $error("boot address not held"); // [R14]

endmodule
`default_nettype wire

/* File: rtl/irq_level_select.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_level_select
  import irq_arbiter_pkg::*;
(
  arb_if.sel bus
);

  // ===========================================================================
  // Winner search
  // Highest level wins; on equal level the earlier (lower) number is kept
  // because only a strictly higher level replaces it.
  always_comb begin
    logic             v;
    logic [SRC_W-1:0] s;
    logic [1:0]       l;
    v = 1'b0;
    s = '0;
    l = '0;
    for (int n = 0; n < NUM_SRC; n++) begin
      if (bus.act[n] && (bus.lvl[n] >= bus.mask) &&  // [R07]
          (!v || (bus.lvl[n] > l))) begin            // [R02]
        v = 1'b1;
        s = SRC_W'(n);
        l = bus.lvl[n];
      end
    end
    bus.win_valid = v;
    bus.win_src   = s;
    bus.win_lvl   = l;
  end

endmodule
`default_nettype wire
